// >>> rtc_control.sv
// RTC control registers, reference lock, square wave, countdown and pins
//
// Behaviour
// - Bit 7 enables locking the time base to the reference clock.
// - Bit 6 chooses square wave (0) or interrupt (1) on shared pin.
// - Bits 5:4 give reference rate: 1Hz, 50Hz, 60Hz, 32.768kHz.
// - Bit 3 set stops the oscillator; resets to stopped.
// - Bits 2:1 pick square wave 1Hz, 4.096k, 8.192k, 32.768k; reset 3.
// - Bit 0 low holds the digital logic in reset; high releases it.
// - Second register bit 6 selects data-retention mode; resets normal.
// - Bit 2 chooses live time (1) or last programmed time on reads.
// - Rising bit 1 loads the time registers into the counter chain.
// - Pause freezes the enabled countdown; clearing resumes from there.
// - Enable low holds countdown in reset; setting it starts counting.
// - Repeat clear halts at zero; set reloads initial value, continues.
// - Countdown rate 1024Hz, 256Hz, 64Hz or 16Hz; resets to 16Hz.
// - Oscillator flag mask forces the oscillator-stopped flag to zero.
// - Bit 2 gates countdown interrupt, bit 1 second alarm; reset 0.
// - In repeat mode a countdown interrupt is raised at start too.
// - Countdown reaching zero sets the flag and raises the interrupt.
// - Bit 0 gates the first alarm interrupt.
`timescale 1ns/1ps
`include "rtc_ctrl_params.svh"
module rtc_control #(
    parameter int COUNT_W  = 8,
    parameter int BASE_CYC = `BASE_TICK_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Register port from the serial target
    input  wire logic [7:0]              regAddr,
    input  wire rtc_ctrl_pkg::reg_byte_t regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output rtc_ctrl_pkg::reg_byte_t      regRdData,
    // Countdown data and flag handling
    input  wire logic [COUNT_W-1:0]      countdownInit,
    output logic      [COUNT_W-1:0]      countdownValue,
    input  wire logic                    doneFlagClear,
    output logic                         countdownDoneFlag,
    // Alarm flags from the match logic
    input  wire logic                    firstAlarmFlag,
    input  wire logic                    secondAlarmFlag,
    // Reference clock pin
    input  wire logic                    referenceClockPin,
    // Time chain controls
    output logic                         secondTick,
    output logic                         loadTimePulse,
    output logic                         readLiveTime,
    output logic                         oscillatorEnable,
    output logic                         oscHaltFlag,
    output logic                         digitalReset,
    output logic                         retentionMode,
    output logic                         busTimeoutEnable,
    // Open-drain interrupt pin
    output logic                         primaryIrqPinOut,
    output logic                         primaryIrqPinOe,
    // Shared interrupt or square-wave pin
    output logic                         sharedPinOut,
    output logic                         sharedPinOe
);
    import rtc_ctrl_pkg::*;

    reg_byte_t         clockOutCfg;
    reg_byte_t         modeSnapCfg;
    reg_byte_t         countdownCfg;
    reg_byte_t         irqEnables;
    reg_byte_t         next_rdData;
    logic              extReferenceEnable;
    logic              sharedPinFunctionSelect;
    rate_sel_t         referenceRateSelect;
    logic              oscillatorDisable;
    rate_sel_t         squareWaveRate;
    logic              softResetN;
    logic              countdownHold;
    logic              countdownRun;
    logic              countdownReloadMode;
    rate_sel_t         countdownTickRate;
    logic              oscFlagMask;
    logic              countdownIrqEnable;
    logic              secondAlarmIrqEnable;
    logic              firstAlarmIrqEnable;
    logic              swReset;
    logic              loadTimePrev;
    logic [15:0]       baseCnt;
    logic              baseTick;
    logic [`PHASE_W-1:0] phase;
    logic [15:0]       phaseMask;
    logic              cdRateTick;
    logic              refMeta;
    logic              refSync;
    logic              refPrev;
    logic              refEdge;
    logic [15:0]       refCnt;
    logic [15:0]       refTarget;
    logic              refSecond;
    logic              squareWave;
    logic              cdExpire;
    logic              cdStart;
    logic              cdIrq;
    logic              alarmIrqA;
    logic              alarmIrqB;

    // Field views of the configuration registers
    assign extReferenceEnable      = clockOutCfg[`BIT_EXT_REF_EN];
    assign sharedPinFunctionSelect = clockOutCfg[`BIT_PIN_FUNC_SEL];
    assign referenceRateSelect     =
        clockOutCfg[`FLD_REF_RATE_HI:`FLD_REF_RATE_LO];
    assign oscillatorDisable       = clockOutCfg[`BIT_OSC_DISABLE];
    assign squareWaveRate          =
        clockOutCfg[`FLD_SQW_RATE_HI:`FLD_SQW_RATE_LO];
    assign softResetN              = clockOutCfg[`BIT_SOFT_RESET_N];
    assign countdownHold           = countdownCfg[`BIT_CD_HOLD];
    assign countdownRun            = countdownCfg[`BIT_CD_RUN];
    assign countdownReloadMode     = countdownCfg[`BIT_CD_RELOAD];
    assign countdownTickRate       =
        countdownCfg[`FLD_CD_RATE_HI:`FLD_CD_RATE_LO];
    assign oscFlagMask             = irqEnables[`BIT_OSC_FLAG_MASK];
    assign countdownIrqEnable      = irqEnables[`BIT_CD_IRQ_EN];
    assign secondAlarmIrqEnable    = irqEnables[`BIT_ALM2_IRQ_EN];
    assign firstAlarmIrqEnable     = irqEnables[`BIT_ALM1_IRQ_EN];

    // Plain mode outputs
    assign swReset          = !softResetN;
    assign digitalReset     = swReset;
    assign retentionMode    = modeSnapCfg[`BIT_RETENTION];
    assign busTimeoutEnable = modeSnapCfg[`BIT_BUS_TIMEOUT_EN];
    assign readLiveTime     = modeSnapCfg[`BIT_READ_LIVE];
    assign oscillatorEnable = !oscillatorDisable;
    // Stopped flag reads zero while masked
    assign oscHaltFlag = oscillatorDisable && !oscFlagMask;

    // Register writes, one byte per access
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clockOutCfg  <= `RST_CLOCK_OUT_CFG;
            modeSnapCfg  <= `RST_MODE_SNAP_CFG;
            countdownCfg <= `RST_COUNTDOWN_CFG;
            irqEnables   <= `RST_IRQ_ENABLES;
        end else if (regWr) begin
            if (regAddr == `ADDR_CLOCK_OUT_CFG) begin
                clockOutCfg <= regWrData & `MASK_CLOCK_OUT_CFG;
            end else if (regAddr == `ADDR_MODE_SNAP_CFG) begin
                modeSnapCfg <= regWrData & `MASK_MODE_SNAP_CFG;
            end else if (regAddr == `ADDR_COUNTDOWN_CFG) begin
                countdownCfg <= regWrData & `MASK_COUNTDOWN_CFG;
            end else if (regAddr == `ADDR_IRQ_ENABLES) begin
                irqEnables <= regWrData & `MASK_IRQ_ENABLES;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdData = `REG_ZERO;
        if (regAddr == `ADDR_CLOCK_OUT_CFG) begin
            next_rdData = clockOutCfg;
        end else if (regAddr == `ADDR_MODE_SNAP_CFG) begin
            next_rdData = modeSnapCfg;
        end else if (regAddr == `ADDR_COUNTDOWN_CFG) begin
            next_rdData = countdownCfg;
        end else if (regAddr == `ADDR_IRQ_ENABLES) begin
            next_rdData = irqEnables;
        end
    end

    // Read data register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= `REG_ZERO;
        end else if (regRd) begin
            regRdData <= next_rdData;
        end
    end

    // Time load on a rising load bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loadTimePrev  <= 1'b0;
            loadTimePulse <= 1'b0;
        end else begin
            loadTimePrev  <= modeSnapCfg[`BIT_LOAD_TIME];
            loadTimePulse <= modeSnapCfg[`BIT_LOAD_TIME] && !loadTimePrev
                             && softResetN;
        end
    end

    // Base tick prescaler; stops with the oscillator
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            baseCnt  <= '0;
            baseTick <= 1'b0;
        end else if (swReset || oscillatorDisable) begin
            baseCnt  <= '0;
            baseTick <= 1'b0;
        end else if (baseCnt >= 16'(BASE_CYC - 1)) begin
            baseCnt  <= '0;
            baseTick <= 1'b1;
        end else begin
            baseCnt  <= baseCnt + 1'b1;
            baseTick <= 1'b0;
        end
    end

    // Reference pin synchroniser and edge detector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refMeta <= 1'b0;
            refSync <= 1'b0;
            refPrev <= 1'b0;
        end else begin
            refMeta <= referenceClockPin;
            refSync <= refMeta;
            refPrev <= refSync;
        end
    end
    assign refEdge = refSync && !refPrev;

    // Reference edges per second for the selected rate
    always_comb begin
        case (referenceRateSelect)
            2'h0:    refTarget = `REF_EDGES_1HZ;
            2'h1:    refTarget = `REF_EDGES_50HZ;
            2'h2:    refTarget = `REF_EDGES_60HZ;
            default: refTarget = `REF_EDGES_32K;
        endcase
    end

    // Reference edge counter marks each locked second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refCnt <= '0;
        end else if (swReset || !extReferenceEnable) begin
            refCnt <= '0;
        end else if (refEdge) begin
            if (refCnt >= refTarget - `REF_CNT_ONE) begin
                refCnt <= '0;
            end else begin
                refCnt <= refCnt + `REF_CNT_ONE;
            end
        end
    end
    assign refSecond = extReferenceEnable && refEdge
                       && (refCnt >= refTarget - `REF_CNT_ONE);

    // Phase counter; realigned to the reference each second when locked
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= `PHASE_ZERO;
        end else if (swReset) begin
            phase <= `PHASE_ZERO;
        end else if (refSecond) begin
            phase <= `PHASE_ZERO;
        end else if (baseTick) begin
            phase <= phase + 1'b1;
        end
    end

    // One-second tick for the time counter chain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secondTick <= 1'b0;
        end else if (extReferenceEnable) begin
            secondTick <= refSecond && softResetN;
        end else begin
            secondTick <= baseTick && (phase == `PHASE_ALL_ONES)
                          && softResetN;
        end
    end

    // Square wave selected from the phase bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            squareWave <= 1'b0;
        end else begin
            case (squareWaveRate)
                2'h0:    squareWave <= phase[`SQW_BIT_1HZ];
                2'h1:    squareWave <= phase[`SQW_BIT_4K];
                2'h2:    squareWave <= phase[`SQW_BIT_8K];
                default: squareWave <= phase[`SQW_BIT_32K];
            endcase
        end
    end

    // Countdown rate tick from the phase counter
    always_comb begin
        case (countdownTickRate)
            2'h0:    phaseMask = `CD_MASK_1024HZ;
            2'h1:    phaseMask = `CD_MASK_256HZ;
            2'h2:    phaseMask = `CD_MASK_64HZ;
            default: phaseMask = `CD_MASK_16HZ;
        endcase
    end
    assign cdRateTick = baseTick && ((phase & phaseMask) == phaseMask);

    // Countdown timer
    rtc_countdown #(
        .COUNT_W (COUNT_W)
    ) u_countdown (
        .clk                 (clk),
        .rst_b               (rst_b),
        .clear               (swReset),
        .countdownRun        (countdownRun),
        .countdownHold       (countdownHold),
        .countdownReloadMode (countdownReloadMode),
        .rateTick            (cdRateTick),
        .initValue           (countdownInit),
        .countValue          (countdownValue),
        .expirePulse         (cdExpire),
        .startPulse          (cdStart)
    );

    // Countdown flag; a set in the clear cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            countdownDoneFlag <= 1'b0;
        end else if (swReset) begin
            countdownDoneFlag <= 1'b0;
        end else if (cdExpire || cdStart) begin
            countdownDoneFlag <= 1'b1;
        end else if (doneFlagClear) begin
            countdownDoneFlag <= 1'b0;
        end
    end

    // Interrupt gating per source
    assign cdIrq = countdownDoneFlag && countdownIrqEnable;
    assign alarmIrqB = secondAlarmFlag && secondAlarmIrqEnable;
    assign alarmIrqA = firstAlarmFlag && firstAlarmIrqEnable;

    // Pin drivers: all sources on the primary pin in square-wave mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            primaryIrqPinOut <= 1'b0;
            primaryIrqPinOe  <= 1'b0;
            sharedPinOut     <= 1'b0;
            sharedPinOe      <= 1'b0;
        end else if (sharedPinFunctionSelect) begin
            // Interrupt mode: shared pin is open drain for countdown, alarm 2
            primaryIrqPinOut <= 1'b0;
            primaryIrqPinOe  <= alarmIrqA;
            sharedPinOut     <= 1'b0;
            sharedPinOe      <= cdIrq || alarmIrqB;
        end else begin
            // Square-wave mode: shared pin driven with the wave
            primaryIrqPinOut <= 1'b0;
            primaryIrqPinOe  <= alarmIrqA || alarmIrqB || cdIrq;
            sharedPinOut     <= squareWave;
            sharedPinOe      <= 1'b1;
        end
    end
endmodule

// >>> rtc_ctrl_params.svh
// Offsets, field positions, reset values and timing counts of the RTC control
`ifndef RTC_CTRL_PARAMS_SVH
`define RTC_CTRL_PARAMS_SVH

// Register offsets
`define ADDR_CLOCK_OUT_CFG   8'h00
`define ADDR_MODE_SNAP_CFG   8'h01
`define ADDR_COUNTDOWN_CFG   8'h03
`define ADDR_IRQ_ENABLES     8'h04

// Reset values and writable bit masks
`define RST_CLOCK_OUT_CFG    8'h0E
`define RST_MODE_SNAP_CFG    8'h0C
`define RST_COUNTDOWN_CFG    8'h07
`define RST_IRQ_ENABLES      8'h00
`define MASK_CLOCK_OUT_CFG   8'hFF
`define MASK_MODE_SNAP_CFG   8'h4E
`define MASK_COUNTDOWN_CFG   8'h37
`define MASK_IRQ_ENABLES     8'h47
`define REG_ZERO             8'h00

// Field positions: clock and output configuration
`define BIT_EXT_REF_EN       7
`define BIT_PIN_FUNC_SEL     6
`define FLD_REF_RATE_HI      5
`define FLD_REF_RATE_LO      4
`define BIT_OSC_DISABLE      3
`define FLD_SQW_RATE_HI      2
`define FLD_SQW_RATE_LO      1
`define BIT_SOFT_RESET_N     0

// Field positions: mode and snapshot configuration
`define BIT_RETENTION        6
`define BIT_BUS_TIMEOUT_EN   3
`define BIT_READ_LIVE        2
`define BIT_LOAD_TIME        1

// Field positions: countdown configuration
`define BIT_CD_HOLD          5
`define BIT_CD_RUN           4
`define BIT_CD_RELOAD        2
`define FLD_CD_RATE_HI       1
`define FLD_CD_RATE_LO       0

// Field positions: interrupt enables
`define BIT_OSC_FLAG_MASK    6
`define BIT_CD_IRQ_EN        2
`define BIT_ALM2_IRQ_EN      1
`define BIT_ALM1_IRQ_EN      0

// Time base: a 65536 Hz tick from the system clock
`define CLK_HZ               50000000
`define BASE_TICK_HZ         65536
`define BASE_TICK_CYC        (`CLK_HZ / `BASE_TICK_HZ)
`define PHASE_W              16
`define PHASE_ALL_ONES       16'hFFFF
`define PHASE_ZERO           16'h0000

// Phase bits that toggle at each square-wave rate
`define SQW_BIT_1HZ          15
`define SQW_BIT_4K           3
`define SQW_BIT_8K           2
`define SQW_BIT_32K          0

// Phase masks that pulse at each countdown rate
`define CD_MASK_1024HZ       16'h003F
`define CD_MASK_256HZ        16'h00FF
`define CD_MASK_64HZ         16'h03FF
`define CD_MASK_16HZ         16'h0FFF

// Reference edges per second for each reference rate
`define REF_EDGES_1HZ        16'd1
`define REF_EDGES_50HZ       16'd50
`define REF_EDGES_60HZ       16'd60
`define REF_EDGES_32K        16'd32768
`define REF_CNT_ONE          16'd1

`endif

// >>> rtc_ctrl_pkg.sv
// Types shared by the RTC control and countdown modules
package rtc_ctrl_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [1:0] rate_sel_t;
    typedef enum logic [1:0] {
        CD_IDLE,
        CD_COUNT,
        CD_HALTED
    } countdown_state_e;
endpackage

// >>> rtc_countdown.sv
// Countdown timer: load, hold, reload and expiry pulses
`timescale 1ns/1ps
module rtc_countdown #(
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    clear,
    // Control
    input  wire logic                    countdownRun,
    input  wire logic                    countdownHold,
    input  wire logic                    countdownReloadMode,
    input  wire logic                    rateTick,
    input  wire logic [COUNT_W-1:0]      initValue,
    // Results
    output logic      [COUNT_W-1:0]      countValue,
    output logic                         expirePulse,
    output logic                         startPulse
);
    import rtc_ctrl_pkg::*;

    countdown_state_e state;
    logic             runPrev;
    logic             runRise;
    logic             decTick;

    assign runRise = countdownRun && !runPrev;
    // Hold freezes the counter only while enabled
    assign decTick = rateTick && !countdownHold;

    // Enable edge detector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            runPrev <= 1'b0;
        end else if (clear) begin
            runPrev <= 1'b0;
        end else begin
            runPrev <= countdownRun;
        end
    end

    // Counter state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= CD_IDLE;
            countValue  <= '0;
            expirePulse <= 1'b0;
            startPulse  <= 1'b0;
        end else if (clear || !countdownRun) begin
            // Held in reset while disabled
            state       <= CD_IDLE;
            countValue  <= '0;
            expirePulse <= 1'b0;
            startPulse  <= 1'b0;
        end else begin
            expirePulse <= 1'b0;
            startPulse  <= 1'b0;
            case (state)
                CD_IDLE: begin
                    if (runRise) begin
                        state      <= CD_COUNT;
                        countValue <= initValue;
                        startPulse <= countdownReloadMode;
                    end
                end
                CD_COUNT: begin
                    if (decTick) begin
                        if (countValue <= 1) begin
                            expirePulse <= 1'b1;
                            if (countdownReloadMode) begin
                                countValue <= initValue;
                            end else begin
                                countValue <= '0;
                                state      <= CD_HALTED;
                            end
                        end else begin
                            countValue <= countValue - 1'b1;
                        end
                    end
                end
                CD_HALTED: begin
                    state <= CD_HALTED;
                end
                default: begin
                    state <= CD_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> rtc_ctrl_assertions.sv
// Checker of register side effects seen at the control block ports
`timescale 1ns/1ps
module rtc_ctrl_assertions (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst_b,
    // Register port
    input wire logic [7:0]              regAddr,
    input wire rtc_ctrl_pkg::reg_byte_t regWrData,
    input wire logic                    regWr,
    input wire logic                    regRd,
    input wire rtc_ctrl_pkg::reg_byte_t regRdData,
    // Levels and pulses
    input wire logic                    countdownDoneFlag,
    input wire logic                    doneFlagClear,
    input wire logic                    digitalReset,
    input wire logic                    oscillatorEnable,
    input wire logic                    oscHaltFlag,
    input wire logic                    retentionMode,
    input wire logic                    busTimeoutEnable,
    input wire logic                    readLiveTime,
    input wire logic                    loadTimePulse
);
    import rtc_ctrl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Write strobe taken at one offset
    sequence wr_at(logic [7:0] a);
        regWr && regAddr == a;
    endsequence
    osc_run_a:
        assert property (wr_at(8'h00)
            |=> oscillatorEnable != $past(regWrData[3]))
        else $error("oscillator enable wrong");
    soft_rst_a:
        assert property (wr_at(8'h00) |=> digitalReset != $past(regWrData[0]))
        else $error("soft reset level wrong");
    retain_mode_a:
        assert property (wr_at(8'h01) |=> retentionMode == $past(regWrData[6]))
        else $error("retention level wrong");
    bus_tmo_a:
        assert property (wr_at(8'h01)
            |=> busTimeoutEnable == $past(regWrData[3]))
        else $error("bus timeout level wrong");
    live_read_a:
        assert property (wr_at(8'h01) |=> readLiveTime == $past(regWrData[2]))
        else $error("live read level wrong");
    halt_mask_a:
        assert property (wr_at(8'h04) ##0 regWrData[6] |=> !oscHaltFlag)
        else $error("halt flag not masked");
    unmapped_read_a:
        assert property (regRd && regAddr == 8'h02 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    done_sticky_a:
        assert property (countdownDoneFlag && !doneFlagClear && !digitalReset
            |=> countdownDoneFlag) else $error("done flag dropped");
    load_pulse_a:
        assert property (loadTimePulse |-> !$past(digitalReset)
            ##1 !loadTimePulse)
        else $error("load pulse wrong");
endmodule
bind rtc_control rtc_ctrl_assertions chk_u (.*);

// >>> rtc_ref_source.sv
// Reference clock source driving the reference pin
`timescale 1ns/1ps
module rtc_ref_source (
    // Control
    input  wire logic run,
    // Pin
    output logic      referenceClockPin
);
    // 160 ns period while running, held low otherwise
    initial referenceClockPin = 1'h0;
    always #80 referenceClockPin = run ? !referenceClockPin : 1'h0;
endmodule

// >>> tb.sv
// Self-checking bench of the control and countdown block
`timescale 1ns/1ps
module tb;
    import rtc_ctrl_pkg::*;
    typedef struct {logic [7:0] a, w, r0, r1;} row_s;
    logic clk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0, refRun = 1'h0;
    logic doneFlagClear = 1'h0, firstAlarmFlag = 1'h0, secondAlarmFlag = 1'h0;
    logic [7:0] regAddr = 8'h00, countdownInit = 8'h03, countdownValue, v;
    reg_byte_t regWrData = 8'h00, regRdData;
    logic countdownDoneFlag, referenceClockPin, secondTick, loadTimePulse;
    logic readLiveTime, oscillatorEnable, oscHaltFlag, digitalReset;
    logic retentionMode, busTimeoutEnable, primaryIrqPinOut, primaryIrqPinOe;
    logic sharedPinOut, sharedPinOe;
    wire [7:0] lvl = {2'h0, oscHaltFlag, digitalReset, oscillatorEnable,
        readLiveTime, busTimeoutEnable, retentionMode};
    wire [7:0] flagPin = {6'h0, countdownDoneFlag, primaryIrqPinOe};
    wire [7:0] pinOe = {6'h0, sharedPinOe, primaryIrqPinOe};
    int n_fail = 0, check_count = 0, nTick = 0, nLoad = 0, t0;
    int lo[4] = '{198, 3, 3, 0}, hi[4] = '{201, 5, 4, 0};
    logic [7:0] tk[4] = '{8'h81, 8'h91, 8'hA1, 8'h01};
    row_s rows[5] = '{'{8'h00, 8'hFE, 8'h0E, 8'hFE},
        '{8'h01, 8'hFF, 8'h0C, 8'h4E}, '{8'h03, 8'hDF, 8'h07, 8'h17},
        '{8'h04, 8'hFF, 8'h00, 8'h47}, '{8'h02, 8'hFF, 8'h00, 8'h00}};
    rtc_control #(.BASE_CYC(2)) dut_u (.*);
    rtc_ref_source ref_u (.run(refRun), .referenceClockPin);
    // Clock, pulse counters and watchdog
    always #10 clk = !clk;
    always @(posedge clk) begin
        nTick += secondTick;
        nLoad += loadTimePulse;
    end
    initial begin
        #400000;
        n_fail++;
        finish_test;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        cyc(1);
        chk("read", e, regRdData);
    endtask
    task automatic clr;
        @(posedge clk);
        doneFlagClear <= 1'h1;
        @(posedge clk);
        doneFlagClear <= 1'h0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(16);
        rst_b <= 1'h1;
        cyc(1);
        chk("levels", 8'h36, lvl);
        foreach (rows[i]) rd(rows[i].a, rows[i].r0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r1);
        end
        chk("levels", 8'h17, lvl);
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h00);
        wr(8'h04, 8'h00);
        cyc(1);
        chk("levels", 8'h30, lvl);
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h02);
        wr(8'h01, 8'h02);
        cyc(4);
        chk("loads", 8'h01, nLoad[7:0]);
        // One-shot countdown from 3 at the fastest rate
        clr;
        wr(8'h04, 8'h04);
        wr(8'h03, 8'h10);
        cyc(4);
        chk("count", 8'h03, countdownValue);
        cyc(700);
        chk("count", 8'h00, countdownValue);
        chk("flag", 8'h03, flagPin);
        clr;
        wr(8'h03, 8'h00);
        cyc(2);
        chk("flag", 8'h00, flagPin);
        // Hold and resume from a frozen count
        countdownInit <= 8'hC8;
        wr(8'h03, 8'h10);
        cyc(300);
        wr(8'h03, 8'h30);
        cyc(4);
        v = countdownValue;
        cyc(600);
        chk("hold", v, countdownValue);
        wr(8'h03, 8'h10);
        cyc(300);
        chk("resume", 8'h01, {7'h0, countdownValue < v});
        wr(8'h03, 8'h00);
        cyc(2);
        chk("count", 8'h00, countdownValue);
        // Repeat mode flags at start and reloads on expiry
        countdownInit <= 8'h02;
        clr;
        wr(8'h03, 8'h14);
        cyc(4);
        chk("flag", 8'h01, {7'h0, countdownDoneFlag});
        clr;
        cyc(600);
        chk("reload", 8'h03, {6'h0, countdownDoneFlag,
            countdownValue != 0});
        wr(8'h03, 8'h00);
        // Alarm gating in interrupt mode
        wr(8'h00, 8'h41);
        firstAlarmFlag <= 1'h1;
        secondAlarmFlag <= 1'h1;
        wr(8'h04, 8'h01);
        cyc(3);
        chk("pins", 8'h01, pinOe);
        wr(8'h04, 8'h02);
        cyc(3);
        chk("pins", 8'h02, pinOe);
        // Reference-locked seconds at 1Hz, 50Hz and 60Hz, then with locking off
        refRun <= 1'h1;
        foreach (tk[i]) begin
            wr(8'h00, tk[i]);
            t0 = nTick;
            cyc(1600);
            chk("ticks", 8'h01, {7'h0,
                (nTick - t0) inside {[lo[i]:hi[i]]}});
        end
        // Fastest square wave toggles every other clock here
        wr(8'h00, 8'h07);
        cyc(4);
        v = {7'h0, sharedPinOut};
        cyc(2);
        chk("wave", {6'h0, !v[0], 1'h0},
            {6'h0, sharedPinOut, primaryIrqPinOut});
        finish_test;
    end
endmodule
